/* File: hdl/dbg_regs_pkg.sv */
// Package with register map, field layout and bus types of the debug housekeeping registers.
package dbg_regs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CLAIM_SET = 12'hFA0;
  localparam logic [11:0] OFS_CLAIM_CLEAR = 12'hFA4;
  localparam logic [11:0] OFS_LOCK_KEY = 12'hFB0;
  localparam logic [11:0] OFS_LOCK_STATUS = 12'hFB4;
  localparam logic [11:0] OFS_AUTH_STATUS = 12'hFB8;
  localparam logic [11:0] OFS_CAPABILITY = 12'hFC8;
  localparam logic [31:0] UNLOCK_KEY = 32'hC5ACCE55;
  localparam int CLAIM_W = 4;
  localparam logic [3:0] CLAIM_IMPL = 4'hF;
  localparam logic [3:0] CLAIM_RESET = 4'h0;
  localparam logic LOCK_RESET = 1'b1;
  localparam int LSR_SIZE_BIT = 2;
  localparam int LSR_ACTIVE_BIT = 1;
  localparam int LSR_PRESENT_BIT = 0;
  localparam logic [1:0] AUTH_SECURE = 2'h0;
  localparam logic [1:0] AUTH_DISABLED = 2'h2;
  localparam logic [1:0] AUTH_ENABLED = 2'h3;
  localparam logic [3:0] CHANNEL_COUNT = 4'h4;
  localparam logic [7:0] TRIGGER_COUNT = 8'h08;
  localparam logic [4:0] EXTERNAL_MUX_COUNT = 5'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic external;
  } bus_req_t;
endpackage

/* File: hdl/debug_lock_claim_status_regs.sv */
// Claim tag, software lock, authentication status and capability registers over Avalon-MM.
//
// Operation
// - Claim clear register reads return current four claim tag bits.
// - Writing ones to claim clear register clears matching tag bits.
// - Writing ones to claim set sets tag bits; reads show implemented bits.
// - Lock blocks only on-chip accesses; external debugger accesses never blocked.
// - Writing the unlock key to lock access register clears the lock.
// - Writing any other value to lock access register sets the lock.
// - While locked, on-chip writes except lock access are discarded; reads served.
// - Lock status reads zero when read from the external debug interface.
// - Lock status bit 2 always reads zero for a 32-bit key register.
// - Lock status bit 1 shows whether requester's writes are blocked.
// - Lock status bit 0 shows lock exists; else key writes ignored.
// - Secure authentication fields always read zero.
// - Non-secure fields read 0b10 disabled, 0b11 enabled.
// - Capability register read-only with channel, trigger and mux counts.
// - Mux count zero means trigger signals are not multiplexed.
`timescale 1ns/10ps
`default_nettype none
module debug_lock_claim_status_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_external,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic nonsecure_invasive_en,
  input wire logic nonsecure_noninvasive_en,
  output logic [3:0] claim_tag,
  output logic lock_active_flag
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DONE = 1'b1
  } bus_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Request capture.

  dbg_regs_pkg::bus_req_t req;
  bus_state_t state_ff;
  bus_state_t nxt_state;
  logic [3:0] claim_ff;
  logic [3:0] nxt_claim;
  logic lock_ff;
  logic nxt_lock;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wait_ff;
  logic nxt_wait;
  logic do_access;
  logic blocked;
  logic [31:0] lsr_val;
  logic [31:0] auth_val;
  logic [31:0] cap_val;
  logic [1:0] nsi_lvl;
  logic [1:0] nsni_lvl;

  // One driver for the whole carrier, fields in declaration order.
  assign req = {avs_read, avs_write, avs_address, avs_writedata, avs_external};

  // Each access is taken in idle and answered on the following edge.
  assign do_access = (state_ff == ST_IDLE) && (req.read || req.write);

  // Only on-chip requests can be held off by the lock.
  assign blocked = lock_ff && !req.external;

  ////////////////////////////////////////////////////////////////////////////////
  // Read values.

  always_comb begin
    nsi_lvl = nonsecure_invasive_en ? dbg_regs_pkg::AUTH_ENABLED
                                    : dbg_regs_pkg::AUTH_DISABLED;
    nsni_lvl = nonsecure_noninvasive_en ? dbg_regs_pkg::AUTH_ENABLED
                                        : dbg_regs_pkg::AUTH_DISABLED;
    auth_val = {24'h000000, dbg_regs_pkg::AUTH_SECURE, dbg_regs_pkg::AUTH_SECURE,
                nsni_lvl, nsi_lvl};
    cap_val = {12'h000, dbg_regs_pkg::CHANNEL_COUNT, dbg_regs_pkg::TRIGGER_COUNT,
               3'h0, dbg_regs_pkg::EXTERNAL_MUX_COUNT};
    lsr_val = 32'h00000000;
    if (!req.external) begin
      lsr_val[dbg_regs_pkg::LSR_PRESENT_BIT] = 1'b1;
      lsr_val[dbg_regs_pkg::LSR_ACTIVE_BIT] = lock_ff;
      lsr_val[dbg_regs_pkg::LSR_SIZE_BIT] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_state = state_ff;
    nxt_claim = claim_ff;
    nxt_lock = lock_ff;
    nxt_rdata = rdata_ff;
    nxt_wait = 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (do_access) begin
          nxt_state = ST_DONE;
          nxt_wait = 1'b0;
          nxt_rdata = dbg_regs_pkg::UNMAPPED_READ;
          if (req.read) begin
            case (req.address)
              dbg_regs_pkg::OFS_CLAIM_SET: begin
                nxt_rdata = {28'h0000000, dbg_regs_pkg::CLAIM_IMPL};
              end
              dbg_regs_pkg::OFS_CLAIM_CLEAR: begin
                nxt_rdata = {28'h0000000, claim_ff};
              end
              dbg_regs_pkg::OFS_LOCK_KEY: begin
                nxt_rdata = 32'h00000000;
              end
              dbg_regs_pkg::OFS_LOCK_STATUS: begin
                nxt_rdata = lsr_val;
              end
              dbg_regs_pkg::OFS_AUTH_STATUS: begin
                nxt_rdata = auth_val;
              end
              dbg_regs_pkg::OFS_CAPABILITY: begin
                nxt_rdata = cap_val;
              end
              default: begin
                nxt_rdata = dbg_regs_pkg::UNMAPPED_READ;
              end
            endcase
          end else begin
            case (req.address)
              dbg_regs_pkg::OFS_CLAIM_SET: begin
                if (!blocked && avs_byteenable[0]) begin
                  nxt_claim = claim_ff | req.writedata[3:0];
                end
              end
              dbg_regs_pkg::OFS_CLAIM_CLEAR: begin
                if (!blocked && avs_byteenable[0]) begin
                  nxt_claim = claim_ff & ~req.writedata[3:0];
                end
              end
              dbg_regs_pkg::OFS_LOCK_KEY: begin
                // External writes see no lock mechanism and are ignored here.
                if (!req.external && (avs_byteenable == 4'hF)) begin
                  nxt_lock = (req.writedata != dbg_regs_pkg::UNLOCK_KEY);
                end
              end
              default: begin
                nxt_lock = lock_ff;
              end
            endcase
          end
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
        nxt_wait = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      claim_ff <= dbg_regs_pkg::CLAIM_RESET;
      lock_ff <= dbg_regs_pkg::LOCK_RESET;
      rdata_ff <= 32'h00000000;
      wait_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      claim_ff <= nxt_claim;
      lock_ff <= nxt_lock;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign claim_tag = claim_ff;
  assign lock_active_flag = lock_ff;

endmodule
`default_nettype wire

/* File: bench/dbg_host_model.sv */
// Bus master model for on-chip software and the external debugger.
`timescale 1ns/10ps
`default_nettype none
module dbg_host_model (
  input wire logic core_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [11:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  output logic avs_external
);
  initial begin
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    avs_external = 1'b0;
  end
  // Holds one access until waitrequest is low, then scrambles the released data.
  task automatic acc(input logic wr, input logic x, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_external <= x;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/debug_lock_claim_status_regs_chk.sv */
// Concurrent checks on the ports of the debug housekeeping register bank.
`timescale 1ns/10ps
`default_nettype none
module debug_lock_claim_status_regs_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_external,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] claim_tag,
  input wire logic lock_active_flag
);
  logic rd, wr, kw, lock_status;
  logic [3:0] wd;
  assign rd = avs_read & avs_waitrequest;
  assign wr = avs_write & avs_waitrequest & (&avs_byteenable);
  assign kw = wr & !avs_external & (avs_address == dbg_regs_pkg::OFS_LOCK_KEY);
  assign lock_status = rd & (avs_address == dbg_regs_pkg::OFS_LOCK_STATUS);
  assign wd = avs_writedata[3:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait");
  bus_answer_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  key_unlock_a: assert property (kw && avs_writedata == dbg_regs_pkg::UNLOCK_KEY
    |=> !lock_active_flag) else $error("no unlock");
  key_relock_a: assert property (kw && avs_writedata != dbg_regs_pkg::UNLOCK_KEY
    |=> lock_active_flag) else $error("no lock");
  claim_set_a: assert property (wr && avs_address == dbg_regs_pkg::OFS_CLAIM_SET
    && !(lock_active_flag && !avs_external) |=> claim_tag == ($past(claim_tag) | $past(wd)))
    else $error("set");
  claim_clr_a: assert property (wr && avs_address == dbg_regs_pkg::OFS_CLAIM_CLEAR
    && !(lock_active_flag && !avs_external) |=> claim_tag == ($past(claim_tag) & ~$past(wd)))
    else $error("clear");
  locked_write_a: assert property (wr && !avs_external && lock_active_flag && !kw
    |=> $stable(claim_tag)) else $error("locked write");
  lsr_ext_a: assert property (lock_status && avs_external |=> avs_readdata == 32'h00000000)
    else $error("lsr ext");
  lsr_chip_a: assert property (lock_status && !avs_external
    |=> avs_readdata == {30'h00000000, $past(lock_active_flag), 1'b1}) else $error("lsr");
  cover property (kw && avs_writedata == dbg_regs_pkg::UNLOCK_KEY);
  cover property (lock_status && avs_external);
  cover property (wr && !avs_external && lock_active_flag && !kw);
endmodule
bind debug_lock_claim_status_regs debug_lock_claim_status_regs_chk i_chk (.core_clk, .rstn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_external,
  .avs_readdata, .avs_waitrequest, .claim_tag, .lock_active_flag);
`default_nettype wire

/* File: bench/debug_lock_claim_status_regs_tb.sv */
// Self-checking bench for the debug housekeeping register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module debug_lock_claim_status_regs_tb;
  logic core_clk, rstn, avs_read, avs_write, avs_external, avs_waitrequest, lock_active_flag;
  logic nonsecure_invasive_en, nonsecure_noninvasive_en;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, claim_tag;
  int error_cnt = 0;
  int total_checks = 0;
  dbg_host_model i_host (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_external);
  debug_lock_claim_status_regs i_dut (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_external, .avs_readdata, .avs_waitrequest,
    .nonsecure_invasive_en, .nonsecure_noninvasive_en, .claim_tag, .lock_active_flag);
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic w(input logic x, input logic [11:0] a, input logic [31:0] d);
    i_host.acc(1'b1, x, a, d, q);
  endtask
  task automatic r(input logic x, input logic [11:0] a, input logic [31:0] e);
    i_host.acc(1'b0, x, a, 32'h00000000, q);
    `CHK("readdata", e, q)
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    nonsecure_invasive_en = 1'b0;
    nonsecure_noninvasive_en = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK("lock", 1'b1, lock_active_flag)
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000003);
    r(1'b1, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000000);
    r(1'b0, dbg_regs_pkg::OFS_LOCK_KEY, 32'h00000000);
    w(1'b0, dbg_regs_pkg::OFS_CLAIM_SET, 32'h0000000F);
    r(1'b0, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h00000000);
    w(1'b1, dbg_regs_pkg::OFS_LOCK_KEY, dbg_regs_pkg::UNLOCK_KEY);
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000003);
    w(1'b1, dbg_regs_pkg::OFS_CLAIM_SET, 32'h00000005);
    r(1'b1, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h00000005);
    w(1'b0, dbg_regs_pkg::OFS_LOCK_KEY, dbg_regs_pkg::UNLOCK_KEY);
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000001);
    w(1'b0, dbg_regs_pkg::OFS_CLAIM_SET, 32'h0000000A);
    r(1'b0, dbg_regs_pkg::OFS_CLAIM_SET, 32'h0000000F);
    r(1'b0, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h0000000F);
    w(1'b0, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h00000006);
    r(1'b0, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h00000009);
    for (int i = 0; i < 4; i++) begin
      nonsecure_invasive_en <= i[0];
      nonsecure_noninvasive_en <= i[1];
      w(1'b0, dbg_regs_pkg::OFS_AUTH_STATUS, 32'hFFFFFFFF);
      r(1'b0, dbg_regs_pkg::OFS_AUTH_STATUS, {28'h0000000, 1'b1, i[1], 1'b1, i[0]});
    end
    w(1'b0, dbg_regs_pkg::OFS_CAPABILITY, 32'hFFFFFFFF);
    r(1'b0, dbg_regs_pkg::OFS_CAPABILITY, {12'h000, dbg_regs_pkg::CHANNEL_COUNT,
      dbg_regs_pkg::TRIGGER_COUNT, 3'h0, dbg_regs_pkg::EXTERNAL_MUX_COUNT});
    r(1'b0, 12'h000, dbg_regs_pkg::UNMAPPED_READ);
    w(1'b0, dbg_regs_pkg::OFS_LOCK_KEY, dbg_regs_pkg::UNLOCK_KEY ^ 32'h00000001);
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000003);
    w(1'b0, dbg_regs_pkg::OFS_CLAIM_CLEAR, 32'h0000000F);
    `CHK("claim", 4'h9, claim_tag)
    w(1'b0, dbg_regs_pkg::OFS_LOCK_KEY, dbg_regs_pkg::UNLOCK_KEY);
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000001);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK("lock", 1'b1, lock_active_flag)
    r(1'b0, dbg_regs_pkg::OFS_LOCK_STATUS, 32'h00000003);
    print_verdict();
  end
endmodule
`default_nettype wire
